// file: omlc_pkg.sv
// ****************************************************************
// constants and types
// ****************************************************************
package omlc_pkg;

  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 16;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [6:0]  GLOBAL_CTRL_OFFSET      = 7'h00;
  localparam logic [6:0]  OUTPUT_MUTE_LOCK_OFFSET = 7'h01;
  localparam logic [15:0] OUTPUT_MUTE_LOCK_RESET  = 16'h10cb;

  localparam int unsigned GLOBAL_RESET_BIT      = 1;
  localparam int unsigned RESERVED_BIT          = 15;
  localparam int unsigned DELAY_SEED_BIT        = 14;
  localparam int unsigned GLOBAL_READBACK_BIT   = 13;
  localparam int unsigned LOCK_TYPE_BIT         = 12;
  localparam int unsigned B_POLARITY_BIT        = 11;
  localparam int unsigned A_POLARITY_BIT        = 10;
  localparam int unsigned B_SOURCE_BIT          = 9;
  localparam int unsigned A_SOURCE_BIT          = 8;
  localparam int unsigned B_MUTE_BIT            = 7;
  localparam int unsigned A_MUTE_BIT            = 6;
  localparam int unsigned B_BUF_PD_BIT          = 5;
  localparam int unsigned A_BUF_PD_BIT          = 4;
  localparam int unsigned DOUBLER_PD_BIT        = 3;
  localparam int unsigned DIVIDER_LSB           = 0;

  // ****************************************************************
  // state-machine clock divider
  // ****************************************************************
  localparam logic [2:0] DIVIDER_MAX_CODE = 3'h5;
  localparam int unsigned DIV_CNT_W       = 5;

  // bit order matches the register layout, msb first
  typedef struct packed {
    logic       reserved;
    logic       delaySeedTuneEnable;
    logic       globalReadback;
    logic       lockDetectType;
    logic       pathBMutePinPolarity;
    logic       pathAMutePinPolarity;
    logic       pathBMuteSource;
    logic       pathAMuteSource;
    logic       pathBMuteBit;
    logic       pathAMuteBit;
    logic       pathBBufferPowerdown;
    logic       pathABufferPowerdown;
    logic       doublerPowerdown;
    logic [2:0] stateMachineClockDivider;
  } omlc_cfg_t;

  typedef struct packed {
    logic        wrEn;
    logic        rdEn;
    logic [6:0]  addr;
    logic [15:0] wrData;
  } omlc_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } omlc_rsp_t;

endpackage : omlc_pkg

// file: omlc_path_mute.sv
`timescale 1ns/1ps
// ****************************************************************
// one output path: pin synchroniser and mute selection
// ****************************************************************
module omlc_path_mute (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic mutePin,
  input  wire logic pinPolarity,
  input  wire logic muteSource,
  input  wire logic muteBit,
  output logic      muted
);

  logic pinMeta_r;
  logic pinMeta_nxt;
  logic pinSync_r;
  logic pinSync_nxt;
  logic muted_r;
  logic muted_nxt;

  always_comb begin
    pinMeta_nxt = mutePin;
    pinSync_nxt = pinMeta_r;
    if (muteSource) begin
      muted_nxt = muteBit;
    end else begin
      // polarity one means the pin mutes while low
      muted_nxt = pinSync_r ^ pinPolarity;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta_r <= 1'b0;
      pinSync_r <= 1'b0;
      muted_r   <= 1'b1;
    end else begin
      pinMeta_r <= pinMeta_nxt;
      pinSync_r <= pinSync_nxt;
      muted_r   <= muted_nxt;
    end
  end

  assign muted = muted_r;

endmodule : omlc_path_mute

// file: omlc_output_mute_lock_config_reg.sv
`timescale 1ns/1ps
// Behaviour
// - bit 15 reads zero; writes to it are discarded.
// - bit 14 enables delay tuning by seeding the fractional modulator.
// - bit 13 selects readback of written values or live machine values.
// - lock type zero: lock after calibration done and delay timeout expired.
// - lock type one (default): also needs tuning voltage within limits.
// - bit 11 polarity of path B mute pin; one mutes when low.
// - bit 10 polarity of path A mute pin; one mutes when low.
// - bit 9 path B mute source: zero pin, one register bit.
// - bit 8 path A mute source: zero pin, one register bit.
// - bit 7 mutes second RF output when set; default set.
// - bit 6 mutes first RF output when set; default set.
// - bit 5 powers off path B output buffer when set.
// - bit 4 powers off path A output buffer when set.
// - bit 3 powers off doubler when set; default set.
// - bits 2..0 divide reference clock by two to the code; codes 6 and 7 divide by 32, as code 5.
// - global reset bit in register zero restores defaults, self-clearing.
module omlc_output_mute_lock_config_reg (
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  input  wire omlc_pkg::omlc_req_t   regReq,
  input  wire logic [15:0]           liveValue,
  input  wire logic                  calibrationDone,
  input  wire logic                  lockDelayTimeoutDone,
  input  wire logic                  vtuneInLimits,
  input  wire logic                  pathAMutePin,
  input  wire logic                  pathBMutePin,
  output omlc_pkg::omlc_rsp_t        regRsp,
  output logic                       globalReset,
  output logic                       delaySeedTuneEnable,
  output logic                       firstRfOutputMute,
  output logic                       secondRfOutputMute,
  output logic                       pathABufferPowerdown,
  output logic                       pathBBufferPowerdown,
  output logic                       doublerPowerdown,
  output logic                       lockDetect,
  output logic                       stateMachineClockEn
);

  // ****************************************************************
  // register write and global reset
  // ****************************************************************
  omlc_pkg::omlc_cfg_t cfg_r;
  omlc_pkg::omlc_cfg_t cfg_nxt;
  logic                globalReset_r;
  logic                globalReset_nxt;
  logic                wrCfg;
  logic                wrGlobal;

  always_comb begin
    wrCfg    = regReq.wrEn && (regReq.addr == omlc_pkg::OUTPUT_MUTE_LOCK_OFFSET);
    wrGlobal = regReq.wrEn && (regReq.addr == omlc_pkg::GLOBAL_CTRL_OFFSET)
               && regReq.wrData[omlc_pkg::GLOBAL_RESET_BIT];
    cfg_nxt  = cfg_r;
    // a one-cycle pulse models the bit returning to zero by itself
    globalReset_nxt = wrGlobal;
    if (wrGlobal) begin
      cfg_nxt = omlc_pkg::omlc_cfg_t'(omlc_pkg::OUTPUT_MUTE_LOCK_RESET);
    end else if (wrCfg) begin
      cfg_nxt          = omlc_pkg::omlc_cfg_t'(regReq.wrData);
      cfg_nxt.reserved = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r         <= omlc_pkg::omlc_cfg_t'(omlc_pkg::OUTPUT_MUTE_LOCK_RESET);
      globalReset_r <= 1'b0;
    end else begin
      cfg_r         <= cfg_nxt;
      globalReset_r <= globalReset_nxt;
    end
  end

  // ****************************************************************
  // readback
  // ****************************************************************
  omlc_pkg::omlc_rsp_t rsp_r;
  omlc_pkg::omlc_rsp_t rsp_nxt;

  always_comb begin
    rsp_nxt.valid = regReq.rdEn;
    rsp_nxt.data  = 16'h0000;
    if (regReq.rdEn && (regReq.addr == omlc_pkg::OUTPUT_MUTE_LOCK_OFFSET)) begin
      if (cfg_r.globalReadback) begin
        rsp_nxt.data = liveValue;
      end else begin
        rsp_nxt.data = 16'(cfg_r);
      end
      rsp_nxt.data[omlc_pkg::RESERVED_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rsp_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

  // ****************************************************************
  // static controls
  // ****************************************************************
  logic ctlSeed_r;
  logic ctlSeed_nxt;
  logic ctlABufPd_r;
  logic ctlABufPd_nxt;
  logic ctlBBufPd_r;
  logic ctlBBufPd_nxt;
  logic ctlDblrPd_r;
  logic ctlDblrPd_nxt;

  always_comb begin
    ctlSeed_nxt   = cfg_r.delaySeedTuneEnable;
    ctlABufPd_nxt = cfg_r.pathABufferPowerdown;
    ctlBBufPd_nxt = cfg_r.pathBBufferPowerdown;
    ctlDblrPd_nxt = cfg_r.doublerPowerdown;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctlSeed_r   <= omlc_pkg::OUTPUT_MUTE_LOCK_RESET[omlc_pkg::DELAY_SEED_BIT];
      ctlABufPd_r <= omlc_pkg::OUTPUT_MUTE_LOCK_RESET[omlc_pkg::A_BUF_PD_BIT];
      ctlBBufPd_r <= omlc_pkg::OUTPUT_MUTE_LOCK_RESET[omlc_pkg::B_BUF_PD_BIT];
      ctlDblrPd_r <= omlc_pkg::OUTPUT_MUTE_LOCK_RESET[omlc_pkg::DOUBLER_PD_BIT];
    end else begin
      ctlSeed_r   <= ctlSeed_nxt;
      ctlABufPd_r <= ctlABufPd_nxt;
      ctlBBufPd_r <= ctlBBufPd_nxt;
      ctlDblrPd_r <= ctlDblrPd_nxt;
    end
  end

  // ****************************************************************
  // output mutes
  // ****************************************************************
  logic pathAMuted;
  logic pathBMuted;

  omlc_path_mute pathAMute (
    .clock       (clock),
    .arst_n      (arst_n),
    .mutePin     (pathAMutePin),
    .pinPolarity (cfg_r.pathAMutePinPolarity),
    .muteSource  (cfg_r.pathAMuteSource),
    .muteBit     (cfg_r.pathAMuteBit),
    .muted       (pathAMuted)
  );

  omlc_path_mute pathBMute (
    .clock       (clock),
    .arst_n      (arst_n),
    .mutePin     (pathBMutePin),
    .pinPolarity (cfg_r.pathBMutePinPolarity),
    .muteSource  (cfg_r.pathBMuteSource),
    .muteBit     (cfg_r.pathBMuteBit),
    .muted       (pathBMuted)
  );

  // ****************************************************************
  // lock detect
  // ****************************************************************
  logic vtuneMeta_r;
  logic vtuneMeta_nxt;
  logic vtuneSync_r;
  logic vtuneSync_nxt;
  logic lock_r;
  logic lock_nxt;
  logic calLock;

  always_comb begin
    vtuneMeta_nxt = vtuneInLimits;
    vtuneSync_nxt = vtuneMeta_r;
    calLock       = calibrationDone && lockDelayTimeoutDone;
    if (cfg_r.lockDetectType) begin
      // comparator checked every cycle, so a drift drops lock three cycles later, after the two-flop synchroniser
      lock_nxt = calLock && vtuneSync_r;
    end else begin
      lock_nxt = calLock;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      vtuneMeta_r <= 1'b0;
      vtuneSync_r <= 1'b0;
      lock_r      <= 1'b0;
    end else begin
      vtuneMeta_r <= vtuneMeta_nxt;
      vtuneSync_r <= vtuneSync_nxt;
      lock_r      <= lock_nxt;
    end
  end

  // ****************************************************************
  // state-machine clock divider
  // ****************************************************************
  logic [4:0] divCnt_r;
  logic [4:0] divCnt_nxt;
  logic       smEn_r;
  logic       smEn_nxt;
  logic [2:0] divCode;
  logic [4:0] divTerm;

  always_comb begin
    // codes 6 and 7 are undefined; clamp to the slowest defined rate
    divCode = cfg_r.stateMachineClockDivider;
    if (divCode > omlc_pkg::DIVIDER_MAX_CODE) begin
      divCode = omlc_pkg::DIVIDER_MAX_CODE;
    end
    divTerm = 5'((6'h01 << divCode) - 6'h01);
    // the host must keep reference over two to the code at or under 50 MHz
    if (divCnt_r >= divTerm) begin
      divCnt_nxt = 5'h00;
      smEn_nxt   = 1'b1;
    end else begin
      divCnt_nxt = divCnt_r + 5'h01;
      smEn_nxt   = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      divCnt_r <= 5'h00;
      smEn_r   <= 1'b0;
    end else begin
      divCnt_r <= divCnt_nxt;
      smEn_r   <= smEn_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign regRsp               = rsp_r;
  assign globalReset          = globalReset_r;
  assign delaySeedTuneEnable  = ctlSeed_r;
  assign firstRfOutputMute    = pathAMuted;
  assign secondRfOutputMute   = pathBMuted;
  assign pathABufferPowerdown = ctlABufPd_r;
  assign pathBBufferPowerdown = ctlBBufPd_r;
  assign doublerPowerdown     = ctlDblrPd_r;
  assign lockDetect           = lock_r;
  assign stateMachineClockEn  = smEn_r;

endmodule : omlc_output_mute_lock_config_reg

// file: omlc_output_mute_lock_config_reg_sva.sv
`timescale 1ns/1ps
// ****************************************************************
// port checker
// ****************************************************************
module omlc_output_mute_lock_config_reg_sva (
  input wire logic                clock,
  input wire logic                arst_n,
  input wire omlc_pkg::omlc_req_t regReq,
  input wire logic [15:0]         liveValue,
  input wire logic                calibrationDone,
  input wire logic                lockDelayTimeoutDone,
  input wire logic                vtuneInLimits,
  input wire logic                pathAMutePin,
  input wire logic                pathBMutePin,
  input wire omlc_pkg::omlc_rsp_t regRsp,
  input wire logic                globalReset,
  input wire logic                delaySeedTuneEnable,
  input wire logic                firstRfOutputMute,
  input wire logic                secondRfOutputMute,
  input wire logic                pathABufferPowerdown,
  input wire logic                pathBBufferPowerdown,
  input wire logic                doublerPowerdown,
  input wire logic                lockDetect,
  input wire logic                stateMachineClockEn
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  logic wrCfg;
  logic wrGlb;
  assign wrCfg = regReq.wrEn && regReq.addr == 7'h01;
  assign wrGlb = regReq.wrEn && regReq.addr == 7'h00 && regReq.wrData[1];

  rsp_valid_a: assert property (regRsp.valid == $past(regReq.rdEn))
    else $error("read answer not one cycle after request");
  rsv_zero_a: assert property (regRsp.valid |-> regRsp.data[15] == 1'b0)
    else $error("reserved bit read as one");
  glob_pulse_a: assert property (wrGlb |=> globalReset)
    else $error("global reset pulse missing");
  lock_cause_a: assert property (lockDetect |-> $past(calibrationDone) && $past(lockDelayTimeoutDone))
    else $error("lock without calibration and timeout");
  seed_copy_a: assert property (wrCfg |-> ##2 delaySeedTuneEnable == $past(regReq.wrData[14], 2))
    else $error("delay seed enable wrong after write");
  bufb_copy_a: assert property (wrCfg |-> ##2 pathBBufferPowerdown == $past(regReq.wrData[5], 2))
    else $error("path b buffer powerdown wrong");
  bufa_copy_a: assert property (wrCfg |-> ##2 pathABufferPowerdown == $past(regReq.wrData[4], 2))
    else $error("path a buffer powerdown wrong");
  dbl_copy_a: assert property (wrCfg |-> ##2 doublerPowerdown == $past(regReq.wrData[3], 2))
    else $error("doubler powerdown wrong");

  glob_c: cover property (globalReset);
  lock_c: cover property (lockDetect);
  smclk_c: cover property (stateMachineClockEn ##1 !stateMachineClockEn);
endmodule : omlc_output_mute_lock_config_reg_sva

// file: omlc_output_mute_lock_config_reg_bench.sv
`timescale 1ns/1ps
// ****************************************************************
// self-checking bench
// ****************************************************************
module omlc_output_mute_lock_config_reg_bench;
  logic                clock = 1'b0;
  logic                arst_n = 1'b0;
  omlc_pkg::omlc_req_t regReq = '0;
  logic [15:0]         liveValue = 16'h0000;
  logic                calDone = 1'b0, tmoDone = 1'b0, vtOk = 1'b0;
  logic                pinA = 1'b0, pinB = 1'b0;
  omlc_pkg::omlc_rsp_t regRsp;
  logic                gRst, seed, path_a_mute_pin, path_b_mute_pin, pdA, pdB, pdDbl, lock, smEn;
  int                  n_fail = 0;
  int                  checks = 0;
  int                  cycles = 0;
  int                  cnt;

  omlc_output_mute_lock_config_reg i_dut (.clock(clock), .arst_n(arst_n), .regReq(regReq),
    .liveValue(liveValue), .calibrationDone(calDone), .lockDelayTimeoutDone(tmoDone),
    .vtuneInLimits(vtOk), .pathAMutePin(pinA), .pathBMutePin(pinB), .regRsp(regRsp),
    .globalReset(gRst), .delaySeedTuneEnable(seed), .firstRfOutputMute(path_a_mute_pin),
    .secondRfOutputMute(path_b_mute_pin), .pathABufferPowerdown(pdA), .pathBBufferPowerdown(pdB),
    .doublerPowerdown(pdDbl), .lockDetect(lock), .stateMachineClockEn(smEn));

  always #10 clock = ~clock;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // budget covers the divider sweep with ample margin
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clock);
    #1 regReq = {1'b1, 1'b0, a, d};
    @(posedge clock);
    #1 regReq = '0;
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    @(posedge clock);
    #1 regReq = {1'b0, 1'b1, a, 16'h0000};
    @(posedge clock);
    #1 regReq = '0;
    chk(16'(regRsp.valid), 16'h0001);
    chk(regRsp.data, exp);
  endtask : rd

  initial begin
    cyc(8);
    chk(16'({seed, path_a_mute_pin, path_b_mute_pin, pdA, pdB, pdDbl, lock, smEn}), 16'h0064);
    arst_n = 1'b1;
    rd(7'h01, 16'h10cb);
    // default source is the pin, so idle low pins leave both paths unmuted
    chk(16'({path_a_mute_pin, path_b_mute_pin, pdA, pdB, pdDbl}), 16'h0001);
    wr(7'h01, 16'hdfff);
    rd(7'h01, 16'h5fff);
    cyc(6);
    chk(16'({seed, path_a_mute_pin, path_b_mute_pin, pdA, pdB, pdDbl}), 16'h003f);
    wr(7'h01, 16'h0300);
    cyc(6);
    chk(16'({seed, path_a_mute_pin, path_b_mute_pin, pdA, pdB, pdDbl}), 16'h0000);
    // pin source: mute follows pin through polarity
    for (int i = 0; i < 4; i++) begin
      wr(7'h01, {4'h0, i[1], i[1], 10'h000});
      pinA = i[0];
      pinB = ~i[0];
      cyc(6);
      chk(16'(path_a_mute_pin), 16'(i[0] ^ i[1]));
      chk(16'(path_b_mute_pin), 16'({~i[0] ^ i[1]}));
    end
    liveValue = 16'hbeef;
    wr(7'h01, 16'h2000);
    rd(7'h01, 16'h3eef);
    wr(7'h01, 16'h0000);
    rd(7'h01, 16'h0000);
    rd(7'h05, 16'h0000);
    calDone = 1'b1;
    tmoDone = 1'b1;
    cyc(6);
    chk(16'(lock), 16'h0001);
    wr(7'h01, 16'h1000);
    cyc(6);
    chk(16'(lock), 16'h0000);
    vtOk = 1'b1;
    cyc(6);
    chk(16'(lock), 16'h0001);
    calDone = 1'b0;
    cyc(3);
    chk(16'(lock), 16'h0000);
    // any phase of the divider gives the same count over 64 cycles
    for (int c = 0; c < 8; c++) begin
      // the 50 MHz reference keeps every code at or under the limit
      wr(7'h01, {13'h0000, c[2:0]});
      cyc(4);
      cnt = 0;
      repeat (64) begin
        cyc(1);
        cnt += int'(smEn);
      end
      chk(16'(cnt), 16'(64 >> (c > 5 ? 5 : c)));
    end
    wr(7'h00, 16'h0002);
    chk(16'(gRst), 16'h0001);
    cyc(2);
    chk(16'(gRst), 16'h0000);
    rd(7'h01, 16'h10cb);
    // pins left at a high, b low with defaults restored: a muted, b not
    chk(16'({path_a_mute_pin, path_b_mute_pin, pdDbl}), 16'h0005);
    end_sim();
  end
endmodule : omlc_output_mute_lock_config_reg_bench

bind omlc_output_mute_lock_config_reg omlc_output_mute_lock_config_reg_sva i_sva (
  .clock                (clock),
  .arst_n               (arst_n),
  .regReq               (regReq),
  .liveValue            (liveValue),
  .calibrationDone      (calibrationDone),
  .lockDelayTimeoutDone (lockDelayTimeoutDone),
  .vtuneInLimits        (vtuneInLimits),
  .pathAMutePin         (pathAMutePin),
  .pathBMutePin         (pathBMutePin),
  .regRsp               (regRsp),
  .globalReset          (globalReset),
  .delaySeedTuneEnable  (delaySeedTuneEnable),
  .firstRfOutputMute    (firstRfOutputMute),
  .secondRfOutputMute   (secondRfOutputMute),
  .pathABufferPowerdown (pathABufferPowerdown),
  .pathBBufferPowerdown (pathBBufferPowerdown),
  .doublerPowerdown     (doublerPowerdown),
  .lockDetect           (lockDetect),
  .stateMachineClockEn  (stateMachineClockEn)
);
